//--- sres_bank.sv
// Receiver error flags, mask and preamble low byte register bank
`default_nettype none
module sres_bank (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire sres_pkg::sres_rx_status_t rx_status_in,
  input wire logic [15:0] preamble_d_in,
  input wire logic [15:0] preamble_c_b_in,
  input wire logic subframe_np_in,
  input wire sres_pkg::sres_req_t req_in,
  output logic [7:0] rdata_out,
  output logic irq_out
);
  // Status flags, mask, and change-tracking state
  logic [7:0] flags_r; // Visible receiver error flags
  logic [7:0] flags_nxt; // Next flag value
  logic [7:0] mask_r; // Interrupt mask, 1 lets a bit through
  logic [7:0] pend_r; // Interrupt pending per bit
  logic [7:0] pend_nxt; // Next pending value
  logic [7:0] live; // Live level of each source
  logic [7:0] prev_r; // Level one cycle back
  logic rd_err; // Error register read taken this edge
  logic wr_mask; // Mask register write taken this edge
  logic [7:0] sticky_ev; // Event-type sources
  logic [7:0] level_chg; // Level sources that moved since last edge
  // Level bits: validity, emphasis, non-PCM, stream, lock
  localparam logic [7:0] LEVEL_MASK = 8'he5;

  // True when a request of the given kind hits the given offset
  function automatic logic req_hits(input sres_pkg::sres_req_t req,
    input logic is_wr, input logic [6:0] addr);
    logic kind_ok;
    kind_ok = is_wr ? req.wr : req.rd;
    return kind_ok && (req.addr == addr);
  endfunction

  // Live status bundle flattened to its bit positions
  assign live = rx_status_in;
  // Only an enabled edge may take a request
  assign rd_err = clk_en_in &&
                  req_hits(req_in, 1'b0, sres_pkg::REG_RX_ERROR_FLAGS);
  assign wr_mask = clk_en_in &&
                   req_hits(req_in, 1'b1, sres_pkg::REG_RX_ERROR_MASK);
  // Event pulses are the bits outside the level set
  assign sticky_ev = live & ~LEVEL_MASK;
  // A level bit that differs from last edge asks for attention
  assign level_chg = (live ^ prev_r) & LEVEL_MASK;

  // Next flag value: levels follow, events stick until read
  always_comb begin
    flags_nxt = (live & LEVEL_MASK);
    // Set wins over clear from the read
    flags_nxt = flags_nxt | sticky_ev |
                (rd_err ? 8'h00 : (flags_r & ~LEVEL_MASK));
  end

  // Pending: level change or new event; read clears
  always_comb begin
    pend_nxt = rd_err ? 8'h00 : pend_r;
    pend_nxt = pend_nxt | level_chg | sticky_ev;
  end

  // Flag register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_r <= sres_pkg::FLAGS_RESET;
      prev_r <= sres_pkg::FLAGS_RESET;
      pend_r <= sres_pkg::FLAGS_RESET;
    end else if (clk_en_in) begin
      flags_r <= flags_nxt;
      prev_r <= live;
      pend_r <= pend_nxt;
    end
  end

  // Mask register write
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mask_r <= sres_pkg::MASK_RESET;
    end else if (wr_mask) begin
      // Writes to other offsets are ignored
      mask_r <= req_in.wdata;
    end
  end

  // Interrupt gating by mask
  assign irq_out = |(pend_r & mask_r);

  // Read data mux, registered
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= 8'h00;
    end else if (clk_en_in && req_in.rd) begin
      case (req_in.addr)
        sres_pkg::REG_PREAMBLE_D_LOW: begin
          if (subframe_np_in) begin
            rdata_out <= preamble_c_b_in[15:8];
          end else if (rx_status_in.non_pcm) begin
            rdata_out <= preamble_d_in[7:0];
          end else begin
            rdata_out <= 8'h00;
          end
        end
        sres_pkg::REG_RX_ERROR_FLAGS: rdata_out <= flags_r;
        sres_pkg::REG_RX_ERROR_MASK: rdata_out <= mask_r;
        default: rdata_out <= 8'h00;
      endcase
    end
  end

  // Properties below watch what this block drives
  // Multi-step behaviours are built from the named sequences
  // Enabled read of the error register
  sequence s_flag_read;
    clk_en_in && req_in.rd &&
      req_in.addr == sres_pkg::REG_RX_ERROR_FLAGS;
  endsequence

  // Enabled preamble read with no compressed data present
  sequence s_pre_plain_read;
    clk_en_in && req_in.rd &&
      req_in.addr == sres_pkg::REG_PREAMBLE_D_LOW &&
      !subframe_np_in && !rx_status_in.non_pcm;
  endsequence

  // Enabled preamble read in per-subframe mode
  sequence s_pre_sub_read;
    clk_en_in && req_in.rd &&
      req_in.addr == sres_pkg::REG_PREAMBLE_D_LOW && subframe_np_in;
  endsequence

  // Enabled edge that carries a line code or parity event
  sequence s_line_event;
    clk_en_in && rx_status_in.line_err;
  endsequence

  // Flag read on an edge with no fresh change or event
  sequence s_quiet_read;
    s_flag_read ##0 (level_chg == 8'h00 && sticky_ev == 8'h00);
  endsequence

  // Line error sticks until a flag read
  chk_line_err_hold: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    flags_r[sres_pkg::BIT_PARITY] && !rd_err |=>
      flags_r[sres_pkg::BIT_PARITY])
    else $error("line error flag dropped without read");

  // Line error event lands in the flag
  chk_line_err_set: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    s_line_event |=> flags_r[sres_pkg::BIT_PARITY])
    else $error("line error event not flagged");

  // Channel-status failure sticks until a flag read
  chk_cs_fail_hold: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    flags_r[sres_pkg::BIT_CS_CHECK] && !rd_err |=>
      flags_r[sres_pkg::BIT_CS_CHECK])
    else $error("check fail flag dropped without read");

  // Emphasis flag follows the live indication
  chk_emph_mirror: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    clk_en_in |=>
      flags_r[sres_pkg::BIT_EMPHASIS] == $past(rx_status_in.emphasis))
    else $error("emphasis flag does not follow input");

  // Stream-absent flag follows the live indication
  chk_stream_mirror: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    clk_en_in |=>
      flags_r[sres_pkg::BIT_NO_STREAM] == $past(rx_status_in.no_stream))
    else $error("stream-absent flag does not follow input");

  // Lock flag follows the live lock state
  chk_lock_mirror: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    clk_en_in |=>
      flags_r[sres_pkg::BIT_LOCK] == $past(rx_status_in.pll_lock))
    else $error("lock flag does not mirror");

  // A quiet read leaves nothing pending, so a steady level is silent
  chk_read_quiets: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    s_quiet_read |=> pend_r == 8'h00)
    else $error("pending bit survived a quiet read");

  // Preamble byte reads zero without compressed data
  chk_pre_zero: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    s_pre_plain_read |=> rdata_out == 8'h00)
    else $error("preamble byte not zero");

  // Per-subframe mode returns the channel B high byte
  chk_pre_sub: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    s_pre_sub_read |=> rdata_out == $past(preamble_c_b_in[15:8]))
    else $error("subframe preamble byte wrong");

  // Nothing may interrupt while the whole mask is clear
  chk_mask_gate: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    mask_r == 8'h00 |-> !irq_out)
    else $error("masked flag raised interrupt");

  // An unmasked pending line error must interrupt
  chk_irq_pass: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    pend_r[sres_pkg::BIT_PARITY] && mask_r[sres_pkg::BIT_PARITY] |->
      irq_out)
    else $error("unmasked line error did not interrupt");

  // A low clock enable freezes all state
  chk_freeze: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    !clk_en_in |=> $stable(flags_r) && $stable(mask_r) &&
      $stable(pend_r) && $stable(rdata_out))
    else $error("state moved while clock enable low");
endmodule // sres_bank
`default_nettype wire

//--- sres_pkg.sv
// Package for the receiver error and preamble status bank
`default_nettype none
package sres_pkg;
  // Register offsets
  localparam logic [6:0] REG_PREAMBLE_D_LOW = 7'h17;
  localparam logic [6:0] REG_RX_ERROR_FLAGS = 7'h18;
  localparam logic [6:0] REG_RX_ERROR_MASK = 7'h19;
  // Bit positions in the error register
  localparam int BIT_LOCK = 0;
  localparam int BIT_PARITY = 1;
  localparam int BIT_NO_STREAM = 2;
  localparam int BIT_CS_CHECK = 3;
  localparam int BIT_NP_PREAMBLE = 4;
  localparam int BIT_NON_PCM = 5;
  localparam int BIT_EMPHASIS = 6;
  localparam int BIT_VALIDITY = 7;
  // Reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // Receiver status carried as one bundle
  typedef struct packed {
    logic validity;
    logic emphasis;
    logic non_pcm;
    logic np_preamble_chg;
    logic cs_check_fail;
    logic no_stream;
    logic line_err;
    logic pll_lock;
  } sres_rx_status_t;
  // Register read/write port request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } sres_req_t;
endpackage
`default_nettype wire

//--- sres_host.sv
// Control processor model issuing register requests
`default_nettype none
module sres_host (
  input wire logic clk_in,
  output sres_pkg::sres_req_t req_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req_out = '0;
  // One request held across exactly one sampling edge
  task automatic access(input logic w, input logic [6:0] a,
    input logic [7:0] d);
    @(posedge clk_in);
    #1 req_out = '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk_in);
    #1 req_out = '0;
  endtask
endmodule // sres_host
`default_nettype wire

//--- spdif_rx_error_status_bench.sv
// Self-checking bench for the receiver error status bank
`default_nettype none
module spdif_rx_error_status_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sub = 1'b0;
  logic en = 1'b1;
  sres_pkg::sres_rx_status_t st = '0;
  sres_pkg::sres_req_t req;
  logic [7:0] rdata;
  logic irq;
  int failures = 0;
  int tests_run = 0;
  always #4 clk = ~clk;
  sres_bank u_dut (.sys_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(en),
    .rx_status_in(st), .preamble_d_in(16'h3c5a), .subframe_np_in(sub),
    .preamble_c_b_in(16'h96e1), .req_in(req), .rdata_out(rdata),
    .irq_out(irq));
  sres_host u_h (.clk_in(clk), .req_out(req));
  // Compare one byte and count it
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Compare the interrupt level and count it
  task automatic cmp_irq(input logic exp);
    tests_run++;
    if (irq !== exp) begin
      failures++;
      $display("BAD %0t irq %b exp %b", $time, irq, exp);
    end
  endtask
  // Let a number of edges pass, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Read a register and compare its value
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    u_h.access(1'b0, a, 8'h00);
    cmp(rdata, e);
  endtask
  // Single-cycle event on one status bit
  task automatic pulse(input int b);
    #8 st[b] = 1'b1;
    #8 st[b] = 1'b0;
  endtask
  // Preamble byte source selection
  task automatic t_pre();
    rd(7'h17, 8'h00);
    st.non_pcm = 1'b1;
    rd(7'h17, 8'h5a);
    sub = 1'b1;
    rd(7'h17, 8'h96);
    sub = 1'b0;
    st.non_pcm = 1'b0;
    rd(7'h18, 8'h00);
    u_h.access(1'b1, 7'h17, 8'hff);
    rd(7'h17, 8'h00);
    u_h.access(1'b1, 7'h18, 8'hff);
    rd(7'h18, 8'h00);
  endtask
  // Held event flags cleared by a read
  task automatic t_stk();
    pulse(1);
    rd(7'h18, 8'h02);
    rd(7'h18, 8'h00);
    pulse(3);
    rd(7'h18, 8'h08);
    rd(7'h18, 8'h00);
  endtask
  // Level flags survive reads and mirror live state
  task automatic t_lvl();
    st.emphasis = 1'b1;
    st.no_stream = 1'b1;
    rd(7'h18, 8'h44);
    rd(7'h18, 8'h44);
    st.validity = 1'b1;
    st.pll_lock = 1'b1;
    rd(7'h18, 8'hc5);
    st = '0;
    rd(7'h18, 8'h00);
  endtask
  // Level flags interrupt on change only, not again after a read
  task automatic t_lvl_irq();
    u_h.access(1'b1, 7'h19, 8'h44);
    cmp_irq(1'b0);
    st.emphasis = 1'b1;
    tick(1);
    cmp_irq(1'b1);
    rd(7'h18, 8'h40);
    cmp_irq(1'b0);
    tick(3);
    cmp_irq(1'b0);
    rd(7'h18, 8'h40);
    st.emphasis = 1'b0;
    tick(1);
    cmp_irq(1'b1);
    rd(7'h18, 8'h00);
    st.no_stream = 1'b1;
    tick(1);
    cmp_irq(1'b1);
    rd(7'h18, 8'h04);
    cmp_irq(1'b0);
    tick(3);
    cmp_irq(1'b0);
    st.no_stream = 1'b0;
    tick(1);
    cmp_irq(1'b1);
    rd(7'h18, 8'h00);
    cmp_irq(1'b0);
    u_h.access(1'b1, 7'h19, 8'h00);
  endtask
  // Clock enable low freezes flags, mask and read data
  task automatic t_en();
    st.non_pcm = 1'b1;
    rd(7'h17, 8'h5a);
    en = 1'b0;
    pulse(1);
    u_h.access(1'b1, 7'h19, 8'hff);
    u_h.access(1'b0, 7'h18, 8'h00);
    cmp(rdata, 8'h5a);
    st.non_pcm = 1'b0;
    en = 1'b1;
    rd(7'h18, 8'h00);
    rd(7'h19, 8'h00);
  endtask
  // Mask gates the interrupt
  task automatic t_irq();
    u_h.access(1'b1, 7'h19, 8'h02);
    pulse(1);
    cmp_irq(1'b1);
    rd(7'h18, 8'h02);
    cmp_irq(1'b0);
    u_h.access(1'b1, 7'h19, 8'h00);
    pulse(1);
    cmp_irq(1'b0);
  endtask
  // Reset in mid-run clears read data, mask and flags
  task automatic t_rst();
    u_h.access(1'b1, 7'h19, 8'h02);
    cmp_irq(1'b1);
    rd(7'h19, 8'h02);
    rst_n = 1'b0;
    tick(2);
    cmp(rdata, 8'h00);
    cmp_irq(1'b0);
    rst_n = 1'b1;
    rd(7'h18, 8'h00);
    rd(7'h19, 8'h00);
  endtask
  // Counts and verdict, then stop
  task automatic conclude();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    t_pre();
    t_stk();
    t_lvl();
    t_lvl_irq();
    t_en();
    t_irq();
    t_rst();
    conclude();
  end
  // Watchdog at about twenty-five times the expected run
  initial begin
    #20000 failures++;
    conclude();
  end
endmodule // spdif_rx_error_status_bench
`default_nettype wire
